/* prim_gate_defs.vh */
// constants for the primitive validity gate
// assumes plain verilog-2005 tools with include paths set to this folder
`ifndef PRIM_GATE_DEFS_VH
`define PRIM_GATE_DEFS_VH

// protocol entity states
`define ST_NULL 3'h0
`define ST_PATH_BY_ACCESS 3'h1
`define ST_PATH_BY_EXCH 3'h2
`define ST_PATH_ACTIVE 3'h3
`define ST_OUT_OF_SERVICE 3'h4
`define ST_PORT_BLOCKED 3'h5

// primitive codes
`define PR_PORT_ELECTRICAL_EVENT 4'h0
`define PR_PATH_SETUP_REQ 4'h1
`define PR_SETUP_POSITIVE_REPLY_IND 4'h2
`define PR_INCOMING_SETUP_IND 4'h3
`define PR_SETUP_CONFIRM 4'h4
`define PR_PATH_CLEAR_REQ 4'h5
`define PR_LINE_INFO_ACK_REQ 4'h6
`define PR_APPLY_CONDITION_REQ 4'h7
`define PR_PORT_EVENT_IND 4'h8
`define PR_PARAM_CHANGE_REQ 4'h9
`define PR_CLEAR_COMPLETE_IND 4'hA

// direction codes
`define DIR_TO_ENTITY 1'b0
`define DIR_FROM_ENTITY 1'b1

// error codes
`define ERR_NONE 2'h0
`define ERR_DIRECTION 2'h1
`define ERR_STATE 2'h2
`define ERR_INFO 2'h3

`endif

/* prim_rule_table.v */
// per-primitive validity lookup: direction, allowed states, info need
// assumes combinational use by the gate on the same clock
`timescale 1ns/100ps
`include "prim_gate_defs.vh"
module prim_rule_table (
    input wire [3:0] prim,
    input wire [2:0] state,
    output reg dir_ok_dir,
    output reg state_ok,
    output reg info_must,
    output reg info_never,
    output reg known
);
    always @* begin
        dir_ok_dir = `DIR_TO_ENTITY;
        state_ok = 1'b0;
        info_must = 1'b0;
        info_never = 1'b0;
        known = 1'b1;
        case (prim)
            `PR_PORT_ELECTRICAL_EVENT: begin
                // valid either way, so the caller skips the direction check
                state_ok = (state == `ST_PATH_ACTIVE);
                info_must = 1'b1;
            end
            `PR_PATH_SETUP_REQ: begin
                state_ok = (state == `ST_NULL) || (state == `ST_PATH_BY_ACCESS);
            end
            `PR_SETUP_POSITIVE_REPLY_IND: begin
                dir_ok_dir = `DIR_FROM_ENTITY;
                state_ok = (state == `ST_PATH_BY_EXCH);
            end
            `PR_INCOMING_SETUP_IND: begin
                dir_ok_dir = `DIR_FROM_ENTITY;
                state_ok = (state == `ST_NULL) || (state == `ST_PATH_BY_EXCH);
            end
            `PR_SETUP_CONFIRM: begin
                state_ok = (state == `ST_PATH_BY_EXCH) || (state == `ST_PATH_BY_ACCESS);
            end
            `PR_PATH_CLEAR_REQ: begin
                state_ok = (state == `ST_PATH_BY_ACCESS) || (state == `ST_PATH_BY_EXCH)
                    || (state == `ST_PATH_ACTIVE);
            end
            `PR_LINE_INFO_ACK_REQ: begin
                state_ok = (state == `ST_PATH_BY_ACCESS);
            end
            `PR_APPLY_CONDITION_REQ: begin
                state_ok = (state == `ST_PATH_ACTIVE);
                info_must = 1'b1;
            end
            `PR_PORT_EVENT_IND: begin
                dir_ok_dir = `DIR_FROM_ENTITY;
                state_ok = (state == `ST_PATH_ACTIVE);
                info_must = 1'b1;
            end
            `PR_PARAM_CHANGE_REQ: begin
                state_ok = (state == `ST_PATH_ACTIVE);
                info_must = 1'b1;
            end
            `PR_CLEAR_COMPLETE_IND: begin
                dir_ok_dir = `DIR_FROM_ENTITY;
                state_ok = (state != `ST_OUT_OF_SERVICE) && (state != `ST_PORT_BLOCKED);
                info_never = 1'b1;
            end
            default: begin
                known = 1'b0;
            end
        endcase
    end
endmodule

/* pstn_primitive_state_gate.v */
// primitive validity gate for the telephony signalling protocol entity
// assumes one clock, primitives from same-clock logic, state supplied by the protocol fsm
// Contract
// - access side passes electrical event primitives both ways, always with details
// - access side accepts or emits electrical event only in path active
// - positive setup reply goes to call control only in path by exchange
// - incoming setup reported only in null or path by exchange
// - port event report only in path active, always with description
// - clear complete report carries no info, not out of service or blocked
`timescale 1ns/100ps
`include "prim_gate_defs.vh"
module pstn_primitive_state_gate (
    input wire core_clk,
    input wire nrst,
    input wire access_side,
    input wire [2:0] entity_state,
    input wire in_valid,
    input wire [3:0] in_prim,
    input wire in_dir,
    input wire in_has_info,
    input wire [15:0] in_info,
    output reg out_valid_q,
    output reg [3:0] out_prim_q,
    output reg out_dir_q,
    output reg out_has_info_q,
    output reg [15:0] out_info_q,
    output reg reject_q,
    output reg [1:0] reject_code_q,
    output reg [3:0] reject_prim_q
);
    wire dir_ok_dir;
    wire state_ok;
    wire info_must;
    wire info_never;
    wire known;
    wire [15:0] info_kept;

    reg side_ok;
    reg dir_ok;
    reg info_ok;
    reg accept;
    reg refuse;
    reg [1:0] err_d;

    reg out_valid_d;
    reg [3:0] out_prim_d;
    reg out_dir_d;
    reg out_has_info_d;
    reg [15:0] out_info_d;
    reg reject_d;
    reg [1:0] reject_code_d;
    reg [3:0] reject_prim_d;
    genvar gi;

    ////////////////////////////////////////////////////////////////////////
    // electrical events are the only access-side primitive
    function is_access_prim;
        input [3:0] p;
        begin
            is_access_prim = (p == `PR_PORT_ELECTRICAL_EVENT);
        end
    endfunction

    // each primitive belongs to one side of the interface
    function side_match;
        input [3:0] p;
        input on_access;
        begin
            side_match = (is_access_prim(p) == on_access);
        end
    endfunction

    // electrical events run both ways, every other primitive one way only
    function dir_match;
        input [3:0] p;
        input d;
        input want_d;
        begin
            dir_match = is_access_prim(p) || (d == want_d);
        end
    endfunction

    // needed detail must be there, forbidden detail must not
    function info_match;
        input must;
        input never;
        input has;
        begin
            info_match = (!must || has) && (!never || !has);
        end
    endfunction

    // direction faults outrank state faults, which outrank info faults
    // unknown codes share the direction fault; the code field has only two bits
    function [1:0] first_fault;
        input k;
        input sd;
        input dr;
        input st;
        input inf;
        begin
            if (!k || !sd || !dr) begin
                first_fault = `ERR_DIRECTION;
            end else if (!st) begin
                first_fault = `ERR_STATE;
            end else if (!inf) begin
                first_fault = `ERR_INFO;
            end else begin
                first_fault = `ERR_NONE;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // clear complete must carry no detail, so each info bit is masked
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_info_mask
            assign info_kept[gi] = in_info[gi] & ~info_never;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    prim_rule_table u_table (
        .prim(in_prim),
        .state(entity_state),
        .dir_ok_dir(dir_ok_dir),
        .state_ok(state_ok),
        .info_must(info_must),
        .info_never(info_never),
        .known(known)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks; the gate never writes entity_state, so rejects leave it untouched
    always @* begin
        // electrical event lives on the access side, the rest on exchange side
        side_ok = side_match(in_prim, access_side);
        dir_ok = dir_match(in_prim, in_dir, dir_ok_dir);
    end

    always @* begin
        info_ok = info_match(info_must, info_never, in_has_info);
    end

    always @* begin
        err_d = first_fault(known, side_ok, dir_ok, state_ok, info_ok);
        accept = in_valid && (err_d == `ERR_NONE);
        refuse = in_valid && (err_d != `ERR_NONE);
    end

    ////////////////////////////////////////////////////////////////////////
    // accepted fields hold until the next accept
    always @* begin
        out_valid_d = accept;
        out_prim_d = out_prim_q;
        out_dir_d = out_dir_q;
        out_has_info_d = out_has_info_q;
        out_info_d = out_info_q;
        if (accept) begin
            out_prim_d = in_prim;
            out_dir_d = in_dir;
            out_has_info_d = in_has_info;
            // clear complete never leaks stale detail; other codes copy in_info even with in_has_info low
            out_info_d = info_kept;
        end
    end

    // refusal fields hold until the next refusal
    always @* begin
        reject_d = refuse;
        reject_code_d = reject_code_q;
        reject_prim_d = reject_prim_q;
        if (refuse) begin
            reject_code_d = err_d;
            reject_prim_d = in_prim;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // one cycle of latency keeps every output on a flop
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            out_valid_q <= 1'b0;
            reject_q <= 1'b0;
        end else begin
            out_valid_q <= out_valid_d;
            reject_q <= reject_d;
        end
    end

    // accepted copy, held between accepts
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            out_prim_q <= 4'h0;
            out_dir_q <= 1'b0;
            out_has_info_q <= 1'b0;
            out_info_q <= 16'h0000;
        end else begin
            out_prim_q <= out_prim_d;
            out_dir_q <= out_dir_d;
            out_has_info_q <= out_has_info_d;
            out_info_q <= out_info_d;
        end
    end

    // refusal report, held between refusals
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reject_code_q <= 2'h0;
            reject_prim_q <= 4'h0;
        end else begin
            reject_code_q <= reject_code_d;
            reject_prim_q <= reject_prim_d;
        end
    end
endmodule

/* gate_checker.sv */
// port assertions for the primitive gate
// assumes a bind onto the gate from the bench top
`timescale 1ns/100ps
module gate_checker (
    input wire core_clk,
    input wire nrst,
    input wire access_side,
    input wire [2:0] entity_state,
    input wire in_valid,
    input wire [3:0] in_prim,
    input wire in_dir,
    input wire in_has_info,
    input wire out_valid_q,
    input wire [3:0] out_prim_q,
    input wire reject_q,
    input wire [1:0] reject_code_q,
    input wire [3:0] reject_prim_q
);
////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    wire ex_ok = !access_side && in_valid;
    sequence s_acc; in_valid ##1 out_valid_q; endsequence
    sequence s_rej; in_valid ##1 reject_q; endsequence
    a_one_answer: assert property (in_valid |=> out_valid_q != reject_q)
        else $error("no single answer");
    a_quiet_idle: assert property (!in_valid |=> !out_valid_q && !reject_q)
        else $error("answer without request");
    a_elec_active: assert property (in_valid && in_prim == 4'h0 && entity_state != 3'h3 |=> reject_q)
        else $error("event outside active");
    a_setup_null: assert property (ex_ok && in_prim == 4'h1 && !in_dir && entity_state == 3'h0 |=> out_valid_q)
        else $error("setup refused in null");
    a_apply_info: assert property (ex_ok && in_prim == 4'h7 && !in_dir && !in_has_info
        && entity_state == 3'h3 |=> reject_code_q == 2'h3)
        else $error("apply without details");
    a_clear_blocked: assert property (ex_ok && in_prim == 4'hA && in_dir
        && entity_state == 3'h5 |=> reject_code_q == 2'h2)
        else $error("clear done while blocked");
    a_accept_copy: assert property (s_acc |-> out_prim_q == $past(in_prim))
        else $error("accepted code lost");
    a_reject_code: assert property (s_rej |-> reject_prim_q == $past(in_prim))
        else $error("rejected code lost");
endmodule

/* prim_source.sv */
// stand-in for call control, user port and state owner
// assumes calls on each cycle from the bench
`timescale 1ns/100ps
module prim_source (
    input wire core_clk,
    output reg access_side,
    output reg [2:0] entity_state,
    output reg in_valid,
    output reg [3:0] in_prim,
    output reg in_dir,
    output reg in_has_info,
    output reg [15:0] in_info
);
////////////////////////////////////////////////////////////////////////////////
    initial {access_side, entity_state, in_valid, in_prim, in_dir, in_has_info, in_info} = 27'h0;
    // unlawful calls are kept on purpose: refusals are under test
    task send(input sd, input [2:0] st, input [3:0] p, input d, input h, input [15:0] i);
        begin
            @(posedge core_clk);
            {access_side, entity_state, in_valid, in_prim} <= {sd, st, 1'b1, p};
            {in_dir, in_has_info, in_info} <= {d, h, i};
        end
    endtask
    // idle drops in_valid and toggles in_info so a stale value never looks valid
    task idle;
        begin
            @(posedge core_clk);
            in_valid <= 1'b0;
            in_info <= ~in_info;
        end
    endtask
endmodule

/* testbench.sv */
// self-checking bench for the primitive gate
// assumes gate, checker and source in this folder
`timescale 1ns/100ps
module testbench;
    reg core_clk = 1'b0;
    reg nrst = 1'b0;
    integer err_count = 0;
    integer n_checks = 0;
    integer seed = 28;
    integer s, st, p, d, rnd;
    reg [1:0] e;
    reg [26:0] cap;
    reg [23:0] want, got;
    reg [23:0] exp_q [$];
    wire access_side, in_valid, in_dir, in_has_info, out_valid_q, out_dir_q, out_has_info_q;
    wire reject_q;
    wire [2:0] entity_state;
    wire [3:0] in_prim, out_prim_q, reject_prim_q;
    wire [15:0] in_info, out_info_q;
    wire [1:0] reject_code_q;
    pstn_primitive_state_gate uut (
        .core_clk(core_clk),
        .nrst(nrst),
        .access_side(access_side),
        .entity_state(entity_state),
        .in_valid(in_valid),
        .in_prim(in_prim),
        .in_dir(in_dir),
        .in_has_info(in_has_info),
        .in_info(in_info),
        .out_valid_q(out_valid_q),
        .out_prim_q(out_prim_q),
        .out_dir_q(out_dir_q),
        .out_has_info_q(out_has_info_q),
        .out_info_q(out_info_q),
        .reject_q(reject_q),
        .reject_code_q(reject_code_q),
        .reject_prim_q(reject_prim_q)
    );
    prim_source pm (
        .core_clk(core_clk),
        .access_side(access_side),
        .entity_state(entity_state),
        .in_valid(in_valid),
        .in_prim(in_prim),
        .in_dir(in_dir),
        .in_has_info(in_has_info),
        .in_info(in_info)
    );
    always #2 core_clk = ~core_clk;
////////////////////////////////////////////////////////////////////////////////
    function [1:0] exp_code(input sd, input [2:0] t, input [3:0] q, input dr, input hi);
        reg [5:0] m;
        reg [15:0] way;
        reg [15:0] need;
        begin
            // set bits: codes sent from the entity, codes that must carry detail
            way = 16'h050C;
            need = 16'h0381;
            case (q)
                4'h1: m = 6'h03;
                4'h2: m = 6'h04;
                4'h3: m = 6'h05;
                4'h4: m = 6'h06;
                4'h5: m = 6'h0E;
                4'h6: m = 6'h02;
                4'hA: m = 6'h0F;
                default: m = 6'h08;
            endcase
            if (q > 4'hA || sd != (q == 4'h0) || (q != 4'h0 && dr != way[q]))
                exp_code = 2'h1;
            else if (!m[t])
                exp_code = 2'h2;
            else if ((!hi && need[q]) || (hi && q == 4'hA))
                exp_code = 2'h3;
            else
                exp_code = 2'h0;
        end
    endfunction
    // inputs caught before this edge's updates land
    always @(posedge core_clk) begin
        cap = {access_side, entity_state, in_valid, in_prim, in_dir, in_has_info, in_info};
        if (cap[22]) begin
            e = exp_code(cap[26], cap[25:23], cap[21:18], cap[17], cap[16]);
            exp_q.push_back(e ? {2'b01, cap[21:18], 16'h0000, e}
                : {2'b10, cap[21:18], cap[17:16], cap[21:18] == 4'hA ? 16'h0000 : cap[15:0]});
        end
        #1;
        n_checks = n_checks + 1;
        if (cap[22]) begin
            want = exp_q.pop_front();
            got = want[22] ? {out_valid_q, reject_q, reject_prim_q, 16'h0000, reject_code_q}
                : {out_valid_q, reject_q, out_prim_q, out_dir_q, out_has_info_q, out_info_q};
        end else begin
            want = 24'h000000;
            got = {out_valid_q, reject_q, 22'h000000};
        end
        if (want !== got) begin
            $display("Error answer expected %h seen %h", want, got);
            err_count = err_count + 1;
        end
    end
    task give_verdict;
        begin
            $display("checks %0d errors %0d", n_checks, err_count);
            if (err_count == 0 && n_checks > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    initial begin
        #20000;
        err_count = err_count + 1;
        give_verdict;
    end
    initial begin
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        // every side, state, code, direction and info flag, back to back
        for (s = 0; s < 2; s = s + 1)
            for (st = 0; st < 6; st = st + 1)
                for (p = 0; p < 12; p = p + 1)
                    for (d = 0; d < 4; d = d + 1) begin
                        rnd = $random(seed);
                        pm.send(s[0], st[2:0], p[3:0], d[0], d[1], rnd[15:0]);
                    end
        pm.idle;
        pm.idle;
        give_verdict;
    end
endmodule
bind pstn_primitive_state_gate gate_checker chk (
    .core_clk(core_clk),
    .nrst(nrst),
    .access_side(access_side),
    .entity_state(entity_state),
    .in_valid(in_valid),
    .in_prim(in_prim),
    .in_dir(in_dir),
    .in_has_info(in_has_info),
    .out_valid_q(out_valid_q),
    .out_prim_q(out_prim_q),
    .reject_q(reject_q),
    .reject_code_q(reject_code_q),
    .reject_prim_q(reject_prim_q)
);
